// >>> bench/clt_host_model.sv
// Host and peripheral side model: indirect writes, FIFO handshakes, original signals
`timescale 1ns/100ps
module clt_host_model (
  input wire logic sys_clk_i,
  input wire logic push_ready_i,
  input wire logic pull_ready_i,
  output logic [5:0] addr_o,
  output logic [31:0] value_o,
  output logic trig_o,
  output logic push_o,
  output logic [31:0] push_data_o,
  output logic pull_o,
  output logic [13:0] orig_o
);
  // Idle values at time zero
  initial begin
    addr_o = '0;
    value_o = '0;
    trig_o = 1'b0;
    push_o = 1'b0;
    push_data_o = '0;
    pull_o = 1'b0;
    orig_o = '0;
  end
  // Originals change every cycle so a stuck mux shows
  always @(negedge sys_clk_i) orig_o <= orig_o + 14'h1;
  // Address, value, then one trigger cycle; stale lines inverted afterwards
  task automatic ind_write(input logic [5:0] a, input logic [31:0] v);
    @(negedge sys_clk_i);
    addr_o = a;
    @(negedge sys_clk_i);
    value_o = v;
    @(negedge sys_clk_i);
    trig_o = 1'b1;
    @(negedge sys_clk_i);
    trig_o = 1'b0;
    addr_o = ~a;
    value_o = ~v;
  endtask
  // Request held until ready is seen ahead of a rising edge; bounded wait
  task automatic xfer(input logic is_push, input logic [31:0] d);
    int n = 0;
    @(negedge sys_clk_i);
    push_o = is_push;
    pull_o = !is_push;
    push_data_o = d;
    #1;
    while (!(is_push ? push_ready_i : pull_ready_i) && n < 20) begin
      n++;
      @(negedge sys_clk_i);
      #1;
    end
    @(negedge sys_clk_i);
    push_o = 1'b0;
    pull_o = 1'b0;
    push_data_o = ~d;
  endtask
endmodule

// >>> bench/clt_tile_asserts.sv
// Port-level concurrent checks for the configurable logic tile
`timescale 1ns/100ps
module clt_tile_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0][4:0] trig_sel_i,
  input wire logic host_pull_i,
  input wire logic [7:0] pwm_sel_i,
  input wire logic [3:0] quad_sel_i,
  input wire logic [7:0] pwm_orig_i,
  input wire logic [3:0] quad_orig_i,
  input wire logic [1:0] cap_sel_i,
  input wire logic [1:0] cap_orig_i,
  input wire logic host_push_ready_o,
  input wire logic host_pull_ready_o,
  input wire logic [31:0] host_pull_data_o,
  input wire logic [7:0] pwm_sig_o,
  input wire logic [3:0] quad_sig_o,
  input wire logic [1:0] cap_sig_o,
  input wire logic [1:0] xbar_out_o,
  input wire logic [7:0] tile_out_o,
  input wire logic [31:0] logic_bus_o,
  input wire logic controller_busy_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [31:0] bus_reg;
  logic [3:0] rise;
  // Previous bus copy, cleared like the tile's own edge detector
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) bus_reg <= '0;
    else bus_reg <= logic_bus_o;
  end
  // Rising selected trigger bits, lowest program index not singled out here
  always_comb begin
    for (int p = 0; p < 4; p++) rise[p] = logic_bus_o[trig_sel_i[p]] & ~bus_reg[trig_sel_i[p]];
  end
  property p_xbar;
    xbar_out_o == tile_out_o[5:4];
  endproperty
  a_xbar: assert property (p_xbar) else $error("crossbar pair wrong");
  property p_pwm;
    pwm_sig_o == ((pwm_sel_i & tile_out_o) | (~pwm_sel_i & pwm_orig_i));
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm substitution wrong");
  property p_quad;
    quad_sig_o == ((quad_sel_i & tile_out_o[3:0]) | (~quad_sel_i & quad_orig_i));
  endproperty
  a_quad: assert property (p_quad) else $error("quadrature substitution wrong");
  property p_cap;
    cap_sig_o == ((cap_sel_i & tile_out_o[7:6]) | (~cap_sel_i & cap_orig_i));
  endproperty
  a_cap: assert property (p_cap) else $error("capture substitution wrong");
  property p_busy_bus;
    logic_bus_o[31] == controller_busy_o;
  endproperty
  a_busy_bus: assert property (p_busy_bus) else $error("busy bit not on bus");
  property p_start;
    !controller_busy_o && (|rise) |=> controller_busy_o;
  endproperty
  a_start: assert property (p_start) else $error("program did not start");
  property p_full;
    logic_bus_o[30] |-> !host_push_ready_o;
  endproperty
  a_full: assert property (p_full) else $error("push taken while full");
  property p_empty;
    logic_bus_o[29] |-> !host_pull_ready_o;
  endproperty
  a_empty: assert property (p_empty) else $error("pull taken while empty");
  property p_hold;
    !(host_pull_i && host_pull_ready_o) |=> $stable(host_pull_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("pull data moved without pull");
  c_start: cover property ($rose(controller_busy_o));
  c_pull: cover property (host_pull_i && host_pull_ready_o);
  c_full: cover property (logic_bus_o[30]);
endmodule
bind clt_tile clt_tile_asserts chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .trig_sel_i(trig_sel_i), .host_pull_i(host_pull_i), .pwm_sel_i(pwm_sel_i),
  .quad_sel_i(quad_sel_i), .pwm_orig_i(pwm_orig_i), .quad_orig_i(quad_orig_i),
  .cap_sel_i(cap_sel_i), .cap_orig_i(cap_orig_i), .cap_sig_o(cap_sig_o),
  .host_push_ready_o(host_push_ready_o), .host_pull_ready_o(host_pull_ready_o),
  .host_pull_data_o(host_pull_data_o), .pwm_sig_o(pwm_sig_o), .quad_sig_o(quad_sig_o),
  .xbar_out_o(xbar_out_o), .tile_out_o(tile_out_o), .logic_bus_o(logic_bus_o),
  .controller_busy_o(controller_busy_o));

// >>> bench/testbench.sv
// Self-checking bench for the configurable logic tile
`timescale 1ns/100ps
module testbench;
  logic sys_clk_i, rst_i, trig, push, pull, push_rdy, pull_rdy, busy, acc = 1'b0;
  logic [71:0] glob;
  logic [24:0] loc;
  logic [31:0] sw, value, pushd, pdata, bus, seed = 32'h25fbe604;
  logic [13:0] sel, orig;
  logic [7:0] tout;
  logic [5:0] addr;
  logic [3:0][4:0] tsel;
  clt_pkg::clt_slice_cfg_t [7:0] scfg;
  clt_pkg::clt_tbl4_cfg_t [2:0] t4cfg;
  clt_pkg::clt_tbl3_cfg_t [7:0] t3cfg;
  clt_pkg::clt_fsm_cfg_t [2:0] fcfg;
  clt_pkg::clt_cnt_cfg_t [2:0] ccfg;
  logic [31:0] notes[$];
  int failures = 0, checks = 0;
  clt_tile #(.TILE_INDEX(2'h2)) uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .global_sig_i(glob), .local_sig_i(loc),
    .software_input_bits_i(sw), .slice_cfg_i(scfg), .tbl4_cfg_i(t4cfg), .tbl3_cfg_i(t3cfg),
    .fsm_cfg_i(fcfg), .cnt_cfg_i(ccfg), .trig_sel_i(tsel), .indirect_write_address_i(addr),
    .indirect_write_value_i(value), .indirect_write_trigger_i(trig), .host_push_i(push),
    .host_push_data_i(pushd), .host_push_ready_o(push_rdy), .host_pull_i(pull),
    .host_pull_ready_o(pull_rdy), .host_pull_data_o(pdata), .pwm_sel_i(sel[7:0]),
    .quad_sel_i(sel[11:8]), .cap_sel_i(sel[13:12]), .pwm_orig_i(orig[7:0]),
    .quad_orig_i(orig[11:8]), .cap_orig_i(orig[13:12]), .pwm_sig_o(), .quad_sig_o(),
    .cap_sig_o(), .xbar_out_o(), .tile_out_o(tout), .logic_bus_o(bus),
    .controller_busy_o(busy));
  clt_host_model host (.sys_clk_i(sys_clk_i), .push_ready_i(push_rdy), .pull_ready_i(pull_rdy),
    .addr_o(addr), .value_o(value), .trig_o(trig), .push_o(push), .push_data_o(pushd),
    .pull_o(pull), .orig_o(orig));
  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    if (notes.size() != 0) failures++;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Pull data is registered at the accepting edge and checked at the next falling edge; oldest note is the expectation
  always @(posedge sys_clk_i) acc <= pull && pull_rdy;
  always @(negedge sys_clk_i) begin
    if (acc && notes.size() == 0) begin
      failures++;
      $display("[FAIL] %0t pull without note", $time);
    end else if (acc) begin
      chk(pdata, notes.pop_front(), "pull data");
    end
  end
  // Watchdog, far beyond the roughly 135 cycles the sequence needs
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
  initial begin
    logic [31:0] a, b, c, e;
    logic [7:0] x;
    int k, n, gi, li;
    logic [10:0] pm [8];
    // ADD r1+=r2, PUSH r1, SUB r2-=r1, PUSH r2, PUSH count0, MOV r0=r1, PUSH r0, HALT
    pm = '{11'h212, 11'h401, 11'h321, 11'h402, 11'h404, 11'h101, 11'h400, 11'h000};
    rst_i = 1'b1;
    glob = '0;
    loc = '0;
    sw = '0;
    sel = '0;
    scfg = '0;
    ccfg = '0;
    tsel = {4{5'h7}};
    t4cfg = '0;
    t4cfg[0].truth = 16'hffff;
    fcfg = '0;
    fcfg[0].next_zero = 16'hffff;
    // Machine 1 in alternate mode gives four-input parity, machine 2 an xor of two inputs
    fcfg[1].alt_mode = 1'b1;
    fcfg[1].in_sel = {5'h1, 5'h0};
    fcfg[1].extra_sel = {5'h3, 5'h2};
    fcfg[1].out_truth = 16'h6996;
    fcfg[2].in_sel = {5'h1, 5'h0};
    fcfg[2].out_truth = 16'h0006;
    // Output tables copy tile input k, so outputs mirror the slices
    for (k = 0; k < 8; k++) t3cfg[k] = '{{5'(k), 5'(k), 5'(k)}, 8'haa};
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    #1;
    chk({bus[29], busy, bus[11], bus[8]}, 4'b1011, "state after reset");
    // Random routing through all eight slices on the direct path
    repeat (20) begin
      @(negedge sys_clk_i);
      e = xs();
      glob = {e[7:0], xs(), xs()};
      loc = 25'(xs());
      sw = xs();
      sel = 14'(xs());
      for (k = 0; k < 8; k++) begin
        e = xs();
        gi = e[6:0] % 72;
        li = e[12:8] % 26;
        scfg[k] = '{7'(gi), 5'(li), 1'b0, clt_pkg::CLT_FILT_PASS, e[16], e[19:17]};
        x[k] = e[16] ? sw[16 + e[19:17]] : (li == 0 ? glob[gi] : loc[li - 1]);
      end
      #1;
      chk(32'(bus[7:0]), 32'(x), "slice routing");
      chk(32'(tout), 32'(x), "tile outputs");
      chk(32'(bus[19:18]), 32'({x[1] ^ x[0], ^x[3:0]}), "machine outputs");
    end
    // Synchronized edge filters: nothing at once, then exactly one pulse
    for (k = 1; k < 3; k++) begin
      @(negedge sys_clk_i);
      scfg[0] = '{7'h0, 5'h0, 1'b1, clt_pkg::clt_filt_t'(k), 1'b0, 3'h0};
      glob[0] = (k == 2);
      repeat (4) @(negedge sys_clk_i);
      glob[0] = (k == 1);
      n = 0;
      #1;
      chk(32'(bus[0]), 32'h0, "synchronizer delay");
      repeat (6) begin
        @(negedge sys_clk_i);
        #1;
        if (bus[0] === 1'b1) n++;
      end
      chk(32'(n), 32'h1, "edge pulse count");
    end
    // Slices 4..7 carry software bits: direction, reset, enable, trigger
    @(negedge sys_clk_i);
    sw = '0;
    for (k = 4; k < 8; k++) scfg[k] = '{7'h0, 5'h0, 1'b0, clt_pkg::CLT_FILT_PASS, 1'b1, 3'(k)};
    ccfg[0] = '{5'h6, 5'h4, 5'h5};
    for (k = 0; k < 8; k++) host.ind_write(6'(k), 32'(pm[k]));
    a = xs();
    b = xs();
    c = xs();
    host.ind_write(6'h21, a);
    host.ind_write(6'h22, b);
    host.ind_write(6'h24, c);
    // Five steps up, two down
    @(negedge sys_clk_i);
    sw[22] = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    sw[20] = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    sw[22] = 1'b0;
    sw[20] = 1'b0;
    @(negedge sys_clk_i);
    sw[23] = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(negedge sys_clk_i);
      n++;
    end
    while (busy !== 1'b0 && n < 60) begin
      @(negedge sys_clk_i);
      n++;
    end
    #1;
    chk({bus[30], push_rdy}, 2'b10, "fifo full after program");
    notes.push_back(a + b);
    notes.push_back(-a);
    notes.push_back(c + 32'h3);
    notes.push_back(a + b);
    repeat (4) host.xfer(1'b0, 32'h0);
    sw[23] = 1'b0;
    @(negedge sys_clk_i);
    #1;
    chk({bus[29], pull_rdy}, 2'b10, "fifo empty after drain");
    // Host fills the shared FIFO with four pushes, checks push ready is low, then drains it in order
    for (k = 0; k < 4; k++) begin
      e = xs();
      notes.push_back(e);
      host.xfer(1'b1, e);
    end
    #1;
    chk({bus[30], push_rdy}, 2'b10, "host fill refused");
    repeat (4) host.xfer(1'b0, 32'h0);
    repeat (2) @(negedge sys_clk_i);
    end_of_test();
  end
endmodule

// >>> rtl/clt_cfg.svh
// Constants for the configurable logic tile: bus positions, map offsets, reset values
`ifndef CLT_CFG_SVH
`define CLT_CFG_SVH
`define CLT_BUS_TBL4_LSB 8
`define CLT_BUS_STATE_LSB 11
`define CLT_BUS_FSMOUT_LSB 17
`define CLT_BUS_CNT_LSB 20
`define CLT_BUS_EMPTY 29
`define CLT_BUS_FULL 30
`define CLT_BUS_BUSY 31
`define CLT_ADDR_REG_BASE 6'h20
`define CLT_NUM_DATA_REGS 13
`define CLT_LAST_PC 3'h7
`define CLT_FIFO_FULL_CNT 3'h4
`define CLT_RST_WORD 32'h0000_0000
`endif

// >>> rtl/clt_input_slice.sv
// One input selector slice: global pick, local pick, optional sync, edge filter, override
`timescale 1ns/100ps
module clt_input_slice #(
  parameter int GLOBAL_N = 72
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  clt_slice_if.slice sl
);
  clt_pkg::clt_slice_state_t state_reg;
  clt_pkg::clt_slice_state_t state_next;
  logic global_bit;
  logic [25:0] local_set;
  logic stage2_bit;
  logic stage3_bit;
  logic filt_bit;

  // Stage chain; sync path adds two cycles of latency
  always_comb begin
    state_next = state_reg;
    global_bit = 1'b0;
    if (int'(sl.cfg.global_sel) < GLOBAL_N) begin
      global_bit = sl.global_bits[sl.cfg.global_sel];
    end
    local_set = {sl.local_bits, global_bit};
    stage2_bit = 1'b0;
    if (sl.cfg.local_sel <= 5'h19) begin
      stage2_bit = local_set[sl.cfg.local_sel];
    end
    state_next.sync1 = stage2_bit;
    state_next.sync2 = state_reg.sync1;
    stage3_bit = sl.cfg.sync_en ? state_reg.sync2 : stage2_bit;
    state_next.prev = stage3_bit;
    // Edge pulses compare with last cycle's stage-3 bit, so they last one cycle
    case (sl.cfg.filt)
      clt_pkg::CLT_FILT_RISE: filt_bit = stage3_bit & ~state_reg.prev;
      clt_pkg::CLT_FILT_FALL: filt_bit = ~stage3_bit & state_reg.prev;
      default: filt_bit = stage3_bit;
    endcase
    sl.slice_out = sl.cfg.sub_en ? sl.sw_bits[sl.cfg.sub_sel] : filt_bit;
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// >>> rtl/clt_pkg.sv
// Types shared by the configurable logic tile and its input slices
package clt_pkg;
  typedef enum logic [1:0] {
    CLT_FILT_PASS = 2'b00,
    CLT_FILT_RISE = 2'b01,
    CLT_FILT_FALL = 2'b10
  } clt_filt_t;
  typedef enum logic [2:0] {
    CLT_OP_HALT = 3'b000,
    CLT_OP_MOV = 3'b001,
    CLT_OP_ADD = 3'b010,
    CLT_OP_SUB = 3'b011,
    CLT_OP_PUSH = 3'b100,
    CLT_OP_PULL = 3'b101
  } clt_op_t;
  typedef struct packed {
    logic [6:0] global_sel;
    logic [4:0] local_sel;
    logic sync_en;
    clt_filt_t filt;
    logic sub_en;
    logic [2:0] sub_sel;
  } clt_slice_cfg_t;
  typedef struct packed {
    logic [3:0][4:0] sel;
    logic [15:0] truth;
  } clt_tbl4_cfg_t;
  typedef struct packed {
    logic [2:0][4:0] sel;
    logic [7:0] truth;
  } clt_tbl3_cfg_t;
  typedef struct packed {
    logic [1:0][4:0] in_sel;
    logic [1:0][4:0] extra_sel;
    logic [15:0] next_zero;
    logic [15:0] next_one;
    logic [15:0] out_truth;
    logic alt_mode;
  } clt_fsm_cfg_t;
  typedef struct packed {
    logic [4:0] en_sel;
    logic [4:0] dir_sel;
    logic [4:0] rst_sel;
  } clt_cnt_cfg_t;
  // Instruction: op[10:8], destination[7:4], source[3:0]
  typedef struct packed {
    clt_op_t op;
    logic [3:0] dst;
    logic [3:0] src;
  } clt_instr_t;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } clt_slice_state_t;
  typedef struct packed {
    logic [31:0] bus_prev;
    logic [12:0][31:0] data;
    logic [31:0][10:0] imem;
    logic [3:0][31:0] fifo;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] fifo_cnt;
    logic [31:0] host_rdata;
    logic busy;
    logic [1:0] prog;
    logic [2:0] pc;
    logic [2:0][1:0] fsm_state;
  } clt_tile_state_t;
endpackage

// >>> rtl/clt_slice_if.sv
// Carrier between the tile and one input slice
`timescale 1ns/100ps
interface clt_slice_if;
  clt_pkg::clt_slice_cfg_t cfg;
  logic [71:0] global_bits;
  logic [24:0] local_bits;
  logic [7:0] sw_bits;
  logic slice_out;
  modport tile (output cfg, output global_bits, output local_bits, output sw_bits,
    input slice_out);
  modport slice (input cfg, input global_bits, input local_bits, input sw_bits,
    output slice_out);
endinterface

// >>> rtl/clt_tile.sv
// Configurable logic tile: input selector, logic primitives, controller, peripheral mux
`timescale 1ns/100ps
`include "clt_cfg.svh"
module clt_tile #(
  parameter logic [1:0] TILE_INDEX = 2'h0,
  parameter int GLOBAL_N = 72
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [71:0] global_sig_i,
  input wire logic [24:0] local_sig_i,
  input wire logic [31:0] software_input_bits_i,
  input wire clt_pkg::clt_slice_cfg_t [7:0] slice_cfg_i,
  input wire clt_pkg::clt_tbl4_cfg_t [2:0] tbl4_cfg_i,
  input wire clt_pkg::clt_tbl3_cfg_t [7:0] tbl3_cfg_i,
  input wire clt_pkg::clt_fsm_cfg_t [2:0] fsm_cfg_i,
  input wire clt_pkg::clt_cnt_cfg_t [2:0] cnt_cfg_i,
  input wire logic [3:0][4:0] trig_sel_i,
  input wire logic [5:0] indirect_write_address_i,
  input wire logic [31:0] indirect_write_value_i,
  input wire logic indirect_write_trigger_i,
  input wire logic host_push_i,
  input wire logic [31:0] host_push_data_i,
  output logic host_push_ready_o,
  input wire logic host_pull_i,
  output logic host_pull_ready_o,
  output logic [31:0] host_pull_data_o,
  input wire logic [7:0] pwm_sel_i,
  input wire logic [3:0] quad_sel_i,
  input wire logic [1:0] cap_sel_i,
  input wire logic [7:0] pwm_orig_i,
  input wire logic [3:0] quad_orig_i,
  input wire logic [1:0] cap_orig_i,
  output logic [7:0] pwm_sig_o,
  output logic [3:0] quad_sig_o,
  output logic [1:0] cap_sig_o,
  output logic [1:0] xbar_out_o,
  output logic [7:0] tile_out_o,
  output logic [31:0] logic_bus_o,
  output logic controller_busy_o
);
  clt_pkg::clt_tile_state_t st_reg;
  clt_pkg::clt_tile_state_t st_next;
  logic [7:0] tile_in;
  logic [31:0] bus_base;
  logic [31:0] logic_bus;
  logic [3:0] trig_edge;
  clt_pkg::clt_instr_t instr;
  logic fifo_full;
  logic fifo_empty;
  logic hlc_push;
  logic hlc_pull;
  logic host_push_ok;
  logic host_pull_ok;
  logic [31:0] push_word;
  logic [4:0] reg_idx;

  // Table lookup shared by every four-input table
  function automatic logic tbl4(input logic [15:0] truth, input logic [3:0] idx);
    return truth[idx];
  endfunction

  // Bus bit pick shared by all primitives
  function automatic logic pick(input logic [31:0] bus, input logic [4:0] sel);
    return bus[sel];
  endfunction

  // Register file read; indices past the data file read zero rather than unknown
  function automatic logic [31:0] rd_reg(input logic [12:0][31:0] d, input logic [3:0] i);
    logic [31:0] v;
    v = '0;
    if (int'(i) < `CLT_NUM_DATA_REGS) begin
      v = d[i];
    end
    return v;
  endfunction

  // Input selector slices, one byte of software bits per tile
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_slice
      clt_slice_if sif();
      // Every slice sees the same global and local buses
      assign sif.cfg = slice_cfg_i[gi];
      assign sif.global_bits = global_sig_i;
      assign sif.local_bits = local_sig_i;
      assign sif.sw_bits = software_input_bits_i[TILE_INDEX*8 +: 8];
      assign tile_in[gi] = sif.slice_out;
      clt_input_slice #(.GLOBAL_N(GLOBAL_N)) u_slice (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .sl(sif)
      );
    end
  endgenerate

  // Slice outputs and registered bus sources; table outputs are layered on top to avoid loops
  always_comb begin
    bus_base = '0;
    bus_base[7:0] = tile_in;
    for (int k = 0; k < 3; k++) begin
      bus_base[`CLT_BUS_STATE_LSB + 2*k +: 2] = st_reg.fsm_state[k];
      // Counter flags are levels that stand while the compare holds
      bus_base[`CLT_BUS_CNT_LSB + 3*k] = (st_reg.data[4 + 3*k] == `CLT_RST_WORD);
      bus_base[`CLT_BUS_CNT_LSB + 3*k + 1] = (st_reg.data[4 + 3*k] == st_reg.data[5 + 3*k]);
      bus_base[`CLT_BUS_CNT_LSB + 3*k + 2] = (st_reg.data[4 + 3*k] == st_reg.data[6 + 3*k]);
    end
    bus_base[`CLT_BUS_EMPTY] = fifo_empty;
    bus_base[`CLT_BUS_FULL] = fifo_full;
    bus_base[`CLT_BUS_BUSY] = st_reg.busy;
  end

  // Four-input tables and machine output tables, purely combinational
  always_comb begin
    logic [3:0] idx;
    logic [1:0] s;
    logic [1:0] ext;
    idx = '0;
    s = '0;
    ext = '0;
    logic_bus = bus_base;
    for (int k = 0; k < 3; k++) begin
      for (int b = 0; b < 4; b++) begin
        idx[b] = pick(bus_base, tbl4_cfg_i[k].sel[b]);
      end
      logic_bus[`CLT_BUS_TBL4_LSB + k] = tbl4(tbl4_cfg_i[k].truth, idx);
      // Machine output table; alternate mode swaps the state bits for extra inputs
      s = st_reg.fsm_state[k];
      ext = {pick(bus_base, fsm_cfg_i[k].in_sel[1]), pick(bus_base, fsm_cfg_i[k].in_sel[0])};
      if (fsm_cfg_i[k].alt_mode) begin
        s = {pick(bus_base, fsm_cfg_i[k].extra_sel[1]),
          pick(bus_base, fsm_cfg_i[k].extra_sel[0])};
      end
      logic_bus[`CLT_BUS_FSMOUT_LSB + k] = tbl4(fsm_cfg_i[k].out_truth, {s, ext});
    end
  end

  // Output tables see the whole bus
  always_comb begin
    logic [2:0] idx;
    idx = '0;
    for (int j = 0; j < 8; j++) begin
      for (int b = 0; b < 3; b++) begin
        idx[b] = pick(logic_bus, tbl3_cfg_i[j].sel[b]);
      end
      tile_out_o[j] = tbl3_cfg_i[j].truth[idx];
    end
  end

  // Peripheral substitution; unselected signals keep their own source
  always_comb begin
    pwm_sig_o = (pwm_sel_i & tile_out_o) | (~pwm_sel_i & pwm_orig_i);
    quad_sig_o = (quad_sel_i & tile_out_o[3:0]) | (~quad_sel_i & quad_orig_i);
    cap_sig_o = (cap_sel_i & tile_out_o[7:6]) | (~cap_sel_i & cap_orig_i);
    xbar_out_o = tile_out_o[5:4];
    logic_bus_o = logic_bus;
    controller_busy_o = st_reg.busy;
    // Pull data is a register, so it stands until the next accepted pull
    host_pull_data_o = st_reg.host_rdata;
  end

  // FIFO arbitration; the controller wins, the host sees ready low that cycle
  always_comb begin
    instr = st_reg.imem[{st_reg.prog, st_reg.pc}];
    fifo_full = (st_reg.fifo_cnt == `CLT_FIFO_FULL_CNT);
    fifo_empty = (st_reg.fifo_cnt == 3'h0);
    hlc_push = st_reg.busy && (instr.op == clt_pkg::CLT_OP_PUSH) && !fifo_full;
    hlc_pull = st_reg.busy && (instr.op == clt_pkg::CLT_OP_PULL) && !fifo_empty;
    host_push_ready_o = !fifo_full && !(st_reg.busy && instr.op == clt_pkg::CLT_OP_PUSH);
    host_pull_ready_o = !fifo_empty && !(st_reg.busy && instr.op == clt_pkg::CLT_OP_PULL);
    host_push_ok = host_push_i && host_push_ready_o;
    host_pull_ok = host_pull_i && host_pull_ready_o;
    push_word = hlc_push ? rd_reg(st_reg.data, instr.src) : host_push_data_i;
    // Edges compare with last cycle's bus copy, so a level held high fires once
    trig_edge = '0;
    for (int p = 0; p < 4; p++) begin
      trig_edge[p] = pick(logic_bus, trig_sel_i[p]) & ~pick(st_reg.bus_prev, trig_sel_i[p]);
    end
    // Wraps for program addresses; only the data-register branch reads it
    reg_idx = 5'(indirect_write_address_i - `CLT_ADDR_REG_BASE);
  end

  // Next state: counters, then indirect writes, then controller writes
  always_comb begin
    logic en;
    logic dn;
    logic [31:0] res;
    en = 1'b0;
    dn = 1'b0;
    res = '0;
    st_next = st_reg;
    st_next.bus_prev = logic_bus;
    // Machine state and counters step once per edge; a counter reset beats its enable
    for (int k = 0; k < 3; k++) begin
      st_next.fsm_state[k][0] = tbl4(fsm_cfg_i[k].next_zero, {st_reg.fsm_state[k],
        pick(bus_base, fsm_cfg_i[k].in_sel[1]), pick(bus_base, fsm_cfg_i[k].in_sel[0])});
      st_next.fsm_state[k][1] = tbl4(fsm_cfg_i[k].next_one, {st_reg.fsm_state[k],
        pick(bus_base, fsm_cfg_i[k].in_sel[1]), pick(bus_base, fsm_cfg_i[k].in_sel[0])});
      en = pick(logic_bus, cnt_cfg_i[k].en_sel);
      dn = pick(logic_bus, cnt_cfg_i[k].dir_sel);
      if (pick(logic_bus, cnt_cfg_i[k].rst_sel)) begin
        st_next.data[4 + 3*k] = `CLT_RST_WORD;
      end else if (en) begin
        st_next.data[4 + 3*k] = dn ? st_reg.data[4 + 3*k] - 32'h1
          : st_reg.data[4 + 3*k] + 32'h1;
      end
    end
    // Indirect path is write-only: nothing here ever returns a value to the host
    if (indirect_write_trigger_i) begin
      if (indirect_write_address_i < `CLT_ADDR_REG_BASE) begin
        st_next.imem[indirect_write_address_i[4:0]] = indirect_write_value_i[10:0];
      end else if (int'(reg_idx) < `CLT_NUM_DATA_REGS) begin
        st_next.data[reg_idx[3:0]] = indirect_write_value_i;
      end
    end
    // FIFO bookkeeping for one push and one pull per cycle
    if (hlc_push || host_push_ok) begin
      st_next.fifo[st_reg.wr_ptr] = push_word;
      st_next.wr_ptr = st_reg.wr_ptr + 2'h1;
    end
    if (hlc_pull || host_pull_ok) begin
      st_next.rd_ptr = st_reg.rd_ptr + 2'h1;
    end
    if (host_pull_ok) begin
      st_next.host_rdata = st_reg.fifo[st_reg.rd_ptr];
    end
    st_next.fifo_cnt = st_reg.fifo_cnt + {2'h0, hlc_push | host_push_ok}
      - {2'h0, hlc_pull | host_pull_ok};
    // Controller: one instruction a cycle, stalls on a full or empty FIFO
    if (!st_reg.busy) begin
      for (int p = 3; p >= 0; p--) begin
        if (trig_edge[p]) begin
          st_next.busy = 1'b1;
          st_next.prog = 2'(p);
          st_next.pc = 3'h0;
        end
      end
    end else begin
      // Result mux; MOV and PUSH take the source unchanged
      res = rd_reg(st_reg.data, instr.src);
      case (instr.op)
        clt_pkg::CLT_OP_ADD: begin
          res = rd_reg(st_reg.data, instr.dst) + rd_reg(st_reg.data, instr.src);
        end
        clt_pkg::CLT_OP_SUB: begin
          res = rd_reg(st_reg.data, instr.dst) - rd_reg(st_reg.data, instr.src);
        end
        clt_pkg::CLT_OP_PULL: res = st_reg.fifo[st_reg.rd_ptr];
        default: res = rd_reg(st_reg.data, instr.src);
      endcase
      // Writes aimed past the data file are dropped
      if ((instr.op == clt_pkg::CLT_OP_MOV || instr.op == clt_pkg::CLT_OP_ADD
          || instr.op == clt_pkg::CLT_OP_SUB || hlc_pull)
          && int'(instr.dst) < `CLT_NUM_DATA_REGS) begin
        st_next.data[instr.dst] = res;
      end
      // A blocked PUSH or PULL holds pc and retries next cycle
      if (instr.op == clt_pkg::CLT_OP_HALT) begin
        st_next.busy = 1'b0;
      end else if ((instr.op == clt_pkg::CLT_OP_PUSH && !hlc_push)
          || (instr.op == clt_pkg::CLT_OP_PULL && !hlc_pull)) begin
        st_next.pc = st_reg.pc;
      end else if (st_reg.pc == `CLT_LAST_PC) begin
        st_next.busy = 1'b0;
      end else begin
        st_next.pc = st_reg.pc + 3'h1;
      end
    end
  end

  // Whole tile state, one register; program memory clears on reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
